/* rtl/alu_exec_cfg.svh */
// Constants for the add, AND and bit-operation execution datapath.
// Operation
// - Add immediate to accumulator, result to accumulator, update carry, digit carry, zero.
// - Add accumulator and addressed register, update carry, digit carry and zero.
// - Register operations write accumulator when destination bit 0, register when 1.
// - AND immediate with accumulator into accumulator, only zero flag changes.
// - AND accumulator with register, route by destination bit, only zero changes.
// - Bit clear forces selected bit zero in register, flags unchanged.
// - Bit set forces selected bit one in register, flags unchanged.
// - Skip-if-zero test discards next instruction when bit clear, taking two cycles.
// - Skip-if-one test discards next instruction when bit set; no flag changes.
// - A successful test spends a second cycle executed as no-operation.
// - Port registers modified from themselves use pin values as source operand.
`ifndef ALU_EXEC_CFG_SVH
`define ALU_EXEC_CFG_SVH
`define DATA_W 8
`define ADDR_W 7
`define ACC_RESET 8'h00
`define CARRY_BIT 8
`define DIGIT_BIT 4
`define DEST_ACC 1'b0
`define DEST_REG 1'b1
`endif

/* rtl/alu_exec_pkg.sv */
// Types shared by the execution datapath.
package alu_exec_pkg;
  typedef enum logic [3:0] {
    OP_NONE                   = 4'b0000,
    OP_ADD_IMMEDIATE_TO_ACC   = 4'b0001,
    OP_ADD_ACC_AND_REG        = 4'b0010,
    OP_AND_IMMEDIATE_WITH_ACC = 4'b0011,
    OP_AND_ACC_WITH_REG       = 4'b0100,
    OP_REG_BIT_CLEAR          = 4'b0101,
    OP_REG_BIT_SET            = 4'b0110,
    OP_TEST_BIT_SKIP_IF_ZERO  = 4'b0111,
    OP_TEST_BIT_SKIP_IF_ONE   = 4'b1000
  } op_t;

  typedef struct packed {
    logic       valid;
    op_t        op;
    logic [7:0] immediate;
    logic [6:0] regAddr;
    logic       dest;
    logic [2:0] bitSel;
  } instr_t;

  typedef struct packed {
    logic       carry;
    logic       digitCarry;
    logic       zero;
  } flags_t;

  typedef struct packed {
    logic       we;
    logic [6:0] addr;
    logic [7:0] data;
  } regWrite_t;
endpackage

/* rtl/alu_adder.sv */
// Eight-bit adder with carry out of bit 7 and bit 3.
`timescale 1ns/100ps
`default_nettype none
`include "alu_exec_cfg.svh"
module alu_adder (
  // Operands
  input  wire logic [7:0] opA,
  input  wire logic [7:0] opB,
  // Results
  output logic      [7:0] sum,
  output logic            carryOut,
  output logic            digitOut
);
  logic [8:0] full;
  logic [4:0] low;

  assign full     = {1'b0, opA} + {1'b0, opB};
  assign low      = {1'b0, opA[3:0]} + {1'b0, opB[3:0]};
  assign sum      = full[7:0];
  assign carryOut = full[`CARRY_BIT];
  assign digitOut = low[`DIGIT_BIT];
endmodule
`default_nettype wire

/* rtl/add_and_bit_ops_exec.sv */
// Execution datapath for add, AND, bit set/clear and bit test instructions.
`timescale 1ns/100ps
`default_nettype none
`include "alu_exec_cfg.svh"
module add_and_bit_ops_exec
  import alu_exec_pkg::*;
(
  // Clock and reset
  input  wire logic      core_clk,
  input  wire logic      rst,
  // Decoded instruction
  input  wire instr_t    instr,
  // Register file read data and port pin view
  input  wire logic [7:0] regRdData,
  input  wire logic [7:0] pinData,
  input  wire logic       regIsPort,
  // Flags in from status register
  input  wire flags_t    flagsIn,
  // Results
  output var regWrite_t  regWr,
  output var flags_t     flags,
  output logic [7:0]     acc,
  output logic           skipNext,
  output logic           nopCycle
);
  logic [7:0] acc_q, acc_d;
  flags_t     flags_q, flags_d;
  regWrite_t  regWr_q, regWr_d;
  logic       nop_q, nop_d;
  logic       skip_q, skip_d;
  logic [7:0] srcOp, addB, addSum, andRes, bitMask, resVal;
  logic       addC, addDc, isAdd, isAnd, toReg, testBit, exec;

  function automatic logic [7:0] bitDecode(input logic [2:0] sel);
    bitDecode = 8'h01 << sel;
  endfunction

  assign srcOp   = regIsPort ? pinData : regRdData;
  assign exec    = instr.valid && !nop_q;
  assign isAdd   = instr.op == OP_ADD_IMMEDIATE_TO_ACC || instr.op == OP_ADD_ACC_AND_REG;
  assign isAnd   = instr.op == OP_AND_IMMEDIATE_WITH_ACC || instr.op == OP_AND_ACC_WITH_REG;
  assign addB    = (instr.op == OP_ADD_IMMEDIATE_TO_ACC) ? instr.immediate : srcOp;
  assign andRes  = acc_q & ((instr.op == OP_AND_IMMEDIATE_WITH_ACC) ? instr.immediate : srcOp);
  assign resVal  = isAdd ? addSum : andRes;
  assign bitMask = bitDecode(instr.bitSel);
  assign testBit = |(srcOp & bitMask);
  assign toReg   = (instr.op == OP_ADD_ACC_AND_REG || instr.op == OP_AND_ACC_WITH_REG)
                   && instr.dest == `DEST_REG;

  alu_adder alu_adder_inst (
    .opA      (acc_q),
    .opB      (addB),
    .sum      (addSum),
    .carryOut (addC),
    .digitOut (addDc)
  );

  always_comb begin
    acc_d   = acc_q;
    flags_d = flagsIn;
    regWr_d = '0;
    skip_d  = 1'b0;
    nop_d   = 1'b0;
    if (exec) begin
      case (instr.op)
        OP_ADD_IMMEDIATE_TO_ACC, OP_ADD_ACC_AND_REG: begin
          flags_d.carry      = addC;
          flags_d.digitCarry = addDc;
          flags_d.zero       = resVal == 8'h00;
        end
        OP_AND_IMMEDIATE_WITH_ACC, OP_AND_ACC_WITH_REG: begin
          flags_d.zero = resVal == 8'h00;
        end
        OP_REG_BIT_CLEAR: begin
          regWr_d = '{we: 1'b1, addr: instr.regAddr, data: srcOp & ~bitMask};
        end
        OP_REG_BIT_SET: begin
          regWr_d = '{we: 1'b1, addr: instr.regAddr, data: srcOp | bitMask};
        end
        OP_TEST_BIT_SKIP_IF_ZERO: begin
          skip_d = !testBit;
        end
        OP_TEST_BIT_SKIP_IF_ONE: begin
          skip_d = testBit;
        end
        default: begin
          skip_d = 1'b0;
        end
      endcase
      if (isAdd || isAnd) begin
        if (toReg) begin
          regWr_d = '{we: 1'b1, addr: instr.regAddr, data: resVal};
        end else begin
          acc_d = resVal;
        end
      end
      nop_d = skip_d;
    end
  end

  // Flags are registered; operations that leave them untouched reload flagsIn unchanged, one cycle later.
  // Writeback lands one cycle after the operand read, so a back-to-back reader of the same register sees the old byte.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      acc_q   <= `ACC_RESET;
      flags_q <= '0;
      regWr_q <= '0;
      nop_q   <= 1'b0;
      skip_q  <= 1'b0;
    end else begin
      acc_q   <= acc_d;
      flags_q <= flags_d;
      regWr_q <= regWr_d;
      nop_q   <= nop_d;
      skip_q  <= skip_d;
    end
  end

  assign acc      = acc_q;
  assign flags    = flags_q;
  assign regWr    = regWr_q;
  assign skipNext = skip_q;
  assign nopCycle = nop_q;

  sequence seqSkipTaken;
    exec && instr.op == OP_TEST_BIT_SKIP_IF_ZERO && !testBit;
  endsequence

  sequence seqNopThenResume;
    nopCycle ##1 !nopCycle;
  endsequence

  sequence seqSkipOneTaken;
    exec && instr.op == OP_TEST_BIT_SKIP_IF_ONE && testBit;
  endsequence

  AST_SKIP_ZERO: assert property (@(posedge core_clk) disable iff (rst)
    seqSkipTaken |=> seqNopThenResume) else $error("skip if zero did not insert one nop");
  AST_SKIP_ONE: assert property (@(posedge core_clk) disable iff (rst)
    exec && instr.op == OP_TEST_BIT_SKIP_IF_ONE |=> nopCycle == $past(testBit) && flags == $past(flagsIn))
    else $error("skip if one wrong");
  AST_NOP_NO_EFFECT: assert property (@(posedge core_clk) disable iff (rst)
    nopCycle |=> !regWr.we && acc == $past(acc) && !nopCycle) else $error("nop cycle changed state");
  AST_ADD_IMM: assert property (@(posedge core_clk) disable iff (rst)
    exec && instr.op == OP_ADD_IMMEDIATE_TO_ACC |=>
      {flags.carry, acc} == {1'b0, $past(acc)} + {1'b0, $past(instr.immediate)})
    else $error("add immediate wrong");
  AST_ADD_REG_DEST: assert property (@(posedge core_clk) disable iff (rst)
    exec && instr.op == OP_ADD_ACC_AND_REG && instr.dest |=>
      regWr.we && regWr.data == 8'($past(acc) + $past(srcOp)) && acc == $past(acc))
    else $error("add register to register wrong");
  AST_AND_IMM: assert property (@(posedge core_clk) disable iff (rst)
    exec && instr.op == OP_AND_IMMEDIATE_WITH_ACC |=>
      acc == ($past(acc) & $past(instr.immediate)) && flags.carry == $past(flagsIn.carry))
    else $error("and immediate wrong");
  AST_AND_REG: assert property (@(posedge core_clk) disable iff (rst)
    exec && instr.op == OP_AND_ACC_WITH_REG && !instr.dest |=>
      acc == ($past(acc) & $past(srcOp)) && !regWr.we && flags.zero == (acc == 8'h00))
    else $error("and register wrong");
  AST_BIT_CLEAR: assert property (@(posedge core_clk) disable iff (rst)
    exec && instr.op == OP_REG_BIT_CLEAR |=>
      regWr.we && !regWr.data[$past(instr.bitSel)] && flags == $past(flagsIn))
    else $error("bit clear wrong");
  AST_BIT_SET: assert property (@(posedge core_clk) disable iff (rst)
    exec && instr.op == OP_REG_BIT_SET |=> regWr.data == ($past(srcOp) | $past(bitMask)))
    else $error("bit set changed other bits");
  AST_PORT_SRC: assert property (@(posedge core_clk) disable iff (rst)
    exec && regIsPort && instr.op == OP_REG_BIT_SET |=> regWr.data == ($past(pinData) | $past(bitMask)))
    else $error("port source not from pins");
  AST_DIGIT: assert property (@(posedge core_clk) disable iff (rst)
    exec && instr.op == OP_ADD_ACC_AND_REG |=>
      flags.digitCarry == (5'($past(acc[3:0])) + 5'($past(srcOp[3:0])) > 5'h0f))
    else $error("digit carry wrong");

  // A taken skip-if-one must insert exactly one nop cycle, after which execution resumes.
  AST_SKIP_ONE_NOP: assert property (@(posedge core_clk) disable iff (rst)
    seqSkipOneTaken |=> seqNopThenResume)
    else $error("skip if one did not insert one nop");
  AST_ADD_REG_ACC: assert property (@(posedge core_clk) disable iff (rst)
    exec && instr.op == OP_ADD_ACC_AND_REG && !instr.dest |=>
      {flags.carry, acc} == {1'b0, $past(acc)} + {1'b0, $past(srcOp)} && !regWr.we)
    else $error("add register to accumulator wrong");
  AST_ADD_ZERO: assert property (@(posedge core_clk) disable iff (rst)
    exec && instr.op == OP_ADD_IMMEDIATE_TO_ACC |=> flags.zero == (acc == 8'h00))
    else $error("zero flag after add wrong");
  AST_AND_REG_DEST: assert property (@(posedge core_clk) disable iff (rst)
    exec && instr.op == OP_AND_ACC_WITH_REG && instr.dest |=>
      regWr.we && regWr.data == ($past(acc) & $past(srcOp)) && regWr.addr == $past(instr.regAddr)
      && acc == $past(acc) && flags.carry == $past(flagsIn.carry) && flags.digitCarry == $past(flagsIn.digitCarry))
    else $error("and register to register wrong");
  AST_BIT_SET_ONE: assert property (@(posedge core_clk) disable iff (rst)
    exec && instr.op == OP_REG_BIT_SET |=>
      regWr.we && regWr.data[$past(instr.bitSel)] && flags == $past(flagsIn) && acc == $past(acc))
    else $error("bit set wrong");
  AST_BIT_CLEAR_KEEP: assert property (@(posedge core_clk) disable iff (rst)
    exec && instr.op == OP_REG_BIT_CLEAR |=>
      regWr.data == ($past(srcOp) & ~$past(bitMask)) && regWr.addr == $past(instr.regAddr))
    else $error("bit clear changed other bits");
  AST_TEST_QUIET: assert property (@(posedge core_clk) disable iff (rst)
    exec && instr.op inside {OP_TEST_BIT_SKIP_IF_ZERO, OP_TEST_BIT_SKIP_IF_ONE} |=>
      !regWr.we && acc == $past(acc) && flags == $past(flagsIn))
    else $error("bit test changed state");
  AST_DISCARD: assert property (@(posedge core_clk) disable iff (rst)
    nopCycle |=> flags == $past(flagsIn) && !skipNext)
    else $error("discarded instruction took effect");
  AST_PORT_ADD: assert property (@(posedge core_clk) disable iff (rst)
    exec && regIsPort && instr.op == OP_ADD_ACC_AND_REG && !instr.dest |=>
      acc == 8'($past(acc) + $past(pinData)))
    else $error("port add not from pins");
endmodule
`default_nettype wire

/* tb/reg_file_model.sv */
// Register file and port pin view that stand in for the core's register file and ports.
`timescale 1ns/100ps
`default_nettype none
module reg_file_model
  import alu_exec_pkg::*;
(
  // Clock
  input  wire logic       core_clk,
  // Access
  input  wire logic [6:0] regAddr,
  input  wire regWrite_t  regWr,
  // Read side
  output logic      [7:0] regRdData,
  output logic      [7:0] pinData,
  output logic            regIsPort
);
  logic [7:0] mem [128];
  // Pins differ from the latches so that a wrong source operand shows up.
  assign regIsPort = regAddr inside {7'h05, 7'h06, 7'h07};
  assign regRdData = mem[regAddr];
  assign pinData   = mem[regAddr] ^ 8'h5a;
  initial foreach (mem[i]) mem[i] = 8'(i * 37);
  always @(posedge core_clk) if (regWr.we) mem[regWr.addr] <= regWr.data;
endmodule
`default_nettype wire

/* tb/add_and_bit_ops_exec_bench.sv */
// Self-checking bench for the execution datapath.
`timescale 1ns/100ps
`default_nettype none
module add_and_bit_ops_exec_bench;
  import alu_exec_pkg::*;
  typedef struct {int due; logic [7:0] acc; flags_t f; regWrite_t w; logic skip;} note_t;
  logic       core_clk, rst, regIsPort, skipNext, nopCycle, pend;
  logic [7:0] regRdData, pinData, acc, expAcc;
  instr_t     instr;
  flags_t     flagsIn, flags;
  regWrite_t  regWr;
  int         cyc, miscompares, testsRun;
  note_t      q[$];

  add_and_bit_ops_exec add_and_bit_ops_exec_inst (.core_clk(core_clk), .rst(rst), .instr(instr),
    .regRdData(regRdData), .pinData(pinData), .regIsPort(regIsPort), .flagsIn(flagsIn),
    .regWr(regWr), .flags(flags), .acc(acc), .skipNext(skipNext), .nopCycle(nopCycle));
  reg_file_model reg_file_model_inst (.core_clk(core_clk), .regAddr(instr.regAddr), .regWr(regWr),
    .regRdData(regRdData), .pinData(pinData), .regIsPort(regIsPort));

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  always @(posedge core_clk) cyc <= cyc + 1;

  task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
    testsRun++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic issue(input op_t op, input logic [7:0] k, input logic [6:0] a);
    note_t n;
    logic [7:0] v, r;
    logic [4:0] lo;
    logic [8:0] s;
    @(posedge core_clk);
    instr <= '{1'b1, op, k, a, 1'($urandom), 3'($urandom)};
    flagsIn <= 3'($urandom);
    #1;
    v = regIsPort ? pinData : regRdData;
    n = '{cyc + 1, expAcc, flagsIn, '0, 1'b0};
    // The instruction after a taken skip is discarded.
    if (pend) pend = 1'b0;
    else begin
      r = (op inside {OP_ADD_IMMEDIATE_TO_ACC, OP_AND_IMMEDIATE_WITH_ACC}) ? k : v;
      s = expAcc + r;
      lo = expAcc[3:0] + r[3:0];
      case (op)
        OP_ADD_IMMEDIATE_TO_ACC, OP_ADD_ACC_AND_REG: n.f = '{s[8], lo[4], s[7:0] == 8'h00};
        OP_AND_IMMEDIATE_WITH_ACC, OP_AND_ACC_WITH_REG: begin
          s = {1'b0, expAcc & r};
          n.f.zero = s[7:0] == 8'h00;
        end
        OP_REG_BIT_CLEAR: n.w = '{1'b1, a, v & ~(8'h01 << instr.bitSel)};
        OP_REG_BIT_SET: n.w = '{1'b1, a, v | (8'h01 << instr.bitSel)};
        OP_TEST_BIT_SKIP_IF_ZERO: n.skip = !v[instr.bitSel];
        OP_TEST_BIT_SKIP_IF_ONE: n.skip = v[instr.bitSel];
        default: ;
      endcase
      if (op inside {OP_ADD_IMMEDIATE_TO_ACC, OP_AND_IMMEDIATE_WITH_ACC}) n.acc = s[7:0];
      else if (op inside {OP_ADD_ACC_AND_REG, OP_AND_ACC_WITH_REG}) begin
        if (instr.dest) n.w = '{1'b1, a, s[7:0]};
        else n.acc = s[7:0];
      end
      pend = n.skip;
    end
    expAcc = n.acc;
    q.push_back(n);
  endtask

  task automatic idle();
    @(posedge core_clk);
    instr.valid <= 1'b0;
    pend = 1'b0;
    repeat (3) @(posedge core_clk);
  endtask

  always @(negedge core_clk) begin
    note_t n;
    if (q.size() > 0 && q[0].due == cyc) begin
      n = q.pop_front();
      cmp("acc", 16'(n.acc), 16'(acc));
      cmp("flags", 16'(n.f), 16'(flags));
      cmp("write", 16'(n.w.we), 16'(regWr.we));
      if (n.w.we) cmp("wrdata", {n.w.addr, n.w.data}, {regWr.addr, regWr.data});
      cmp("skip", {n.skip, n.skip}, {skipNext, nopCycle});
    end
  end

  task automatic tally_and_finish();
    if (miscompares == 0 && testsRun > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    #120000;
    miscompares++;
    tally_and_finish();
  end

  initial begin
    void'($urandom(32'hcd99a649));
    rst = 1'b1;
    instr = '0;
    flagsIn = '0;
    expAcc = '0;
    pend = 1'b0;
    cyc = 0;
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    // Carry out of both nibbles with a zero sum.
    issue(OP_AND_IMMEDIATE_WITH_ACC, 8'h00, 7'h00);
    issue(OP_ADD_IMMEDIATE_TO_ACC, 8'hff, 7'h00);
    issue(OP_ADD_IMMEDIATE_TO_ACC, 8'h01, 7'h00);
    issue(OP_REG_BIT_SET, 8'h00, 7'h05);
    repeat (600) issue(op_t'($urandom_range(0, 8)), 8'($urandom), 7'($urandom_range(0, 15)));
    idle();
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    expAcc = '0;
    issue(OP_ADD_IMMEDIATE_TO_ACC, 8'h0f, 7'h00);
    idle();
    tally_and_finish();
  end
endmodule
`default_nettype wire
